// ==== hw/motion_link_pkg.sv ====
/*
 Constants, timing counts and types shared by both ends of the motion line link.
 Assumes a single 125 MHz system clock on each end.
*/
`default_nettype none
package motion_link_pkg;
   localparam real CLK_MHZ = 125.0;
   localparam int CLK_HZ = 125000000;
   function automatic int cyc_min(input real us);
      int c;
      c = int'($ceil(us * CLK_MHZ));
      return (c < 1) ? 1 : c;
   endfunction
   function automatic int cyc_max(input real us);
      int c;
      c = int'($floor(us * CLK_MHZ));
      return (c < 1) ? 1 : c;
   endfunction
   localparam real T_WIN_MIN_MS = 4.55;
   localparam real T_WIN_MAX_MS = 5.56;
   localparam real T_MOT_NOM_MS = 5.0;
   localparam real T_HIB_MIN_MS = 0.91;
   localparam real T_HIB_NOM_MS = 1.0;
   localparam real T_THR_MIN_US [3] = '{562.5, 1125.0, 2250.0};
   localparam real T_THR_MAX_US [3] = '{883.0, 1570.0, 2950.0};
   localparam real T_THR_NOM_US [3] = '{625.0, 1250.0, 2500.0};
   localparam real T_SAMPLE_READY_PULSE_NOM_US = 32.0;
   localparam real T_BOOT_LO_US = 64.0;
   localparam real T_BOOT_HI_MS = 10.0;
   localparam real T_FLT_LINE_US = 10.0;
   localparam real T_FLT_WAKE_NS = 400.0;
   localparam real T_SETTLE_US = 100.0;
   localparam real T_TON_BASE_US = 528.5;
   localparam real TON_SLOPE = 0.9984;
   localparam real T_HOST_WAKE_US = 100.0;
   localparam real T_WAKE_N_US = 1.0;
   localparam int C_WIN_MIN = cyc_max(T_WIN_MIN_MS * 1000.0);
   localparam int C_WIN_MAX = cyc_max(T_WIN_MAX_MS * 1000.0);
   localparam int C_MOT_NOM = cyc_min(T_MOT_NOM_MS * 1000.0);
   localparam int C_HIB_MIN = cyc_min(T_HIB_MIN_MS * 1000.0);
   localparam int C_HIB_NOM = cyc_min(T_HIB_NOM_MS * 1000.0);
   localparam int C_THR_MIN [3] = '{cyc_min(T_THR_MIN_US[0]), cyc_min(T_THR_MIN_US[1]), cyc_min(T_THR_MIN_US[2])};
   localparam int C_THR_MAX [3] = '{cyc_max(T_THR_MAX_US[0]), cyc_max(T_THR_MAX_US[1]), cyc_max(T_THR_MAX_US[2])};
   localparam int C_THR_NOM [3] = '{cyc_min(T_THR_NOM_US[0]), cyc_min(T_THR_NOM_US[1]), cyc_min(T_THR_NOM_US[2])};
   localparam int C_SAMPLE_READY_PULSE = cyc_min(T_SAMPLE_READY_PULSE_NOM_US);
   localparam int C_BOOT_LO = cyc_min(T_BOOT_LO_US);
   localparam int C_BOOT_HI = cyc_min(T_BOOT_HI_MS * 1000.0);
   localparam int C_FLT_LINE = cyc_min(T_FLT_LINE_US);
   localparam int C_FLT_WAKE = cyc_min(T_FLT_WAKE_NS / 1000.0);
   localparam int C_SETTLE = cyc_min(T_SETTLE_US);
   localparam int C_TON_BASE = cyc_min(T_TON_BASE_US);
   localparam int C_HOST_WAKE = cyc_min(T_HOST_WAKE_US);
   localparam int C_WAKE_N = cyc_min(T_WAKE_N_US);
   localparam int ODR_DEFAULT_HZ = 100;
   localparam int DEC_DEFAULT = 4;
   localparam int ODR_TOL_PCT = 10;
   localparam int I2C_SM_KHZ = 100;
   localparam int I2C_FM_KHZ = 400;
   localparam int I2C_FMP_KHZ = 1000;
   localparam logic signed [7:0] TEMP_ZERO_C = 8'sh19;
   localparam logic [1:0] THR_RESET = 2'h0;
   localparam int CNT_W = 24;
   typedef logic [CNT_W-1:0] cnt_t;
   function automatic int period_cyc(input int rate_hz);
      return CLK_HZ / rate_hz;
   endfunction
   function automatic int ton_extra_cyc(input int rate_hz, input int dec);
      return int'($floor(TON_SLOPE * real'(dec - 1) * real'(CLK_HZ) / (real'(rate_hz) * real'(dec))));
   endfunction
endpackage
`default_nettype wire

// ==== hw/motion_link_if.sv ====
/*
 Pin bundle between the sensor end and the host end.
 Assumes the motion line is open drain with a pull-up: any enabled low driver wins.
*/
`default_nettype none
interface motion_link_if;
   logic boot_config_pin;
   logic host_port_select;
   logic wake_n;
   logic boot_done;
   logic sample_ready_pulse;
   logic motion_line_dev_out;
   logic motion_line_dev_oe;
   logic motion_line_host_out;
   logic motion_line_host_oe;
   logic motion_line;
   assign motion_line = !((motion_line_dev_oe && !motion_line_dev_out) ||
                          (motion_line_host_oe && !motion_line_host_out));
   modport dev(input boot_config_pin, input host_port_select, input wake_n, input motion_line,
               output boot_done, output sample_ready_pulse, output motion_line_dev_out,
               output motion_line_dev_oe);
   modport host(output boot_config_pin, output host_port_select, output wake_n,
                output motion_line_host_out, output motion_line_host_oe,
                input motion_line, input boot_done, input sample_ready_pulse);
endinterface
`default_nettype wire

// ==== hw/motion_link_device.sv ====
/*
 Sensor end: boot sequencing, threshold decode, motion pulses, hibernation and sample pacing.
 Assumes the interface resolves the open-drain motion line; pins arrive asynchronously.
*/
`default_nettype none
module motion_link_device
   import motion_link_pkg::*;
#(
   parameter int SAMPLE_RATE_HZ = ODR_DEFAULT_HZ,
   parameter int DECIMATION = DEC_DEFAULT,
   parameter int SETTLE_CYC = C_SETTLE,
   parameter int BOOT_HI_CYC = C_BOOT_HI,
   parameter int WIN_CYC = C_WIN_MAX,
   parameter int MOT_PULSE_CYC = C_MOT_NOM,
   parameter int HIB_LOW_CYC = C_HIB_MIN,
   parameter int TON_BASE_CYC = C_TON_BASE,
   parameter int SAMPLE_PERIOD_CYC = period_cyc(SAMPLE_RATE_HZ),
   parameter int THR_MIN_CYC [3] = C_THR_MIN,
   parameter int THR_MAX_CYC [3] = C_THR_MAX
) (
   input wire logic clk_sys_i,
   input wire logic rst_i,
   motion_link_if.dev link,
   input wire logic motion_event_i,
   input wire logic active_req_i,
   input wire logic hibernate_req_i,
   input wire logic reduced_power_operation_i,
   input wire logic signed [7:0] temp_celsius_i,
   output logic signed [7:0] temp_code_o,
   output logic [1:0] threshold_o,
   output logic hibernating_o,
   output logic motion_mode_o,
   output logic i2c_port_en_o
);
   typedef enum logic [2:0] {ST_SETTLE, ST_STANDBY, ST_ACTIVE, ST_WINDOW, ST_MOTION, ST_HIB} dev_state_e;

   // decimation is forced to one in reduced power, so only the base latency remains
   localparam int TON_FULL_CYC = TON_BASE_CYC + ton_extra_cyc(SAMPLE_RATE_HZ, DECIMATION);
   localparam int FLT_CYC [2] = '{C_FLT_LINE, C_FLT_WAKE};

   logic [3:0] s1_reg;
   logic [3:0] s2_reg;
   logic [1:0] filt;
   logic line_f;
   logic wake_f;
   logic port_sel_s;
   logic boot_pin_s;

   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         s1_reg <= 4'h3;
         s2_reg <= 4'h3;
      end else begin
         s1_reg <= {link.host_port_select, link.boot_config_pin, link.wake_n, link.motion_line};
         s2_reg <= s1_reg;
      end
   end
   assign port_sel_s = s2_reg[3];
   assign boot_pin_s = s2_reg[2];

   // a level change is taken only after it has held for the full filter time
   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : g_flt
         logic f_reg;
         logic f_next;
         logic [10:0] c_reg;
         logic [10:0] c_next;
         always_comb begin
            f_next = f_reg;
            c_next = 11'h0;
            if (s2_reg[g] != f_reg) begin
               if (c_reg == 11'(FLT_CYC[g] - 1)) begin
                  f_next = s2_reg[g];
               end else begin
                  c_next = c_reg + 11'h1;
               end
            end
         end
         always_ff @(posedge clk_sys_i or posedge rst_i) begin
            if (rst_i) begin
               f_reg <= 1'b1;
               c_reg <= 11'h0;
            end else begin
               f_reg <= f_next;
               c_reg <= c_next;
            end
         end
         assign filt[g] = f_reg;
      end
   endgenerate
   assign line_f = filt[0];
   assign wake_f = filt[1];

   dev_state_e state_reg, state_next;
   cnt_t tmr_reg, tmr_next;
   cnt_t bootp_reg, bootp_next;
   cnt_t sample_ready_pulse_reg, sample_ready_pulse_next;
   cnt_t mpulse_reg, mpulse_next;
   cnt_t low_reg, low_next;
   logic own_reg, own_next;
   logic line_q_reg, line_q_next;
   logic first_reg, first_next;
   logic boot_cfg_reg, boot_cfg_next;
   logic [1:0] thr_reg, thr_next;
   logic signed [7:0] temp_reg, temp_next;
   logic port_en_reg, port_en_next;
   cnt_t sample_target;
   cnt_t hib_target;

   always_comb begin
      state_next = state_reg;
      tmr_next = tmr_reg + cnt_t'(1);
      bootp_next = (bootp_reg != '0) ? bootp_reg - cnt_t'(1) : bootp_reg;
      sample_ready_pulse_next = (sample_ready_pulse_reg != '0) ? sample_ready_pulse_reg - cnt_t'(1) : sample_ready_pulse_reg;
      mpulse_next = (mpulse_reg != '0) ? mpulse_reg - cnt_t'(1) : mpulse_reg;
      low_next = line_f ? '0 : low_reg + cnt_t'(1);
      own_next = own_reg;
      line_q_next = line_f;
      first_next = first_reg;
      boot_cfg_next = boot_cfg_reg;
      thr_next = thr_reg;
      temp_next = temp_celsius_i - TEMP_ZERO_C;
      port_en_next = !port_sel_s;
      if (reduced_power_operation_i) begin
         sample_target = first_reg ? cnt_t'(TON_BASE_CYC) : cnt_t'(SAMPLE_PERIOD_CYC);
      end else begin
         sample_target = first_reg ? cnt_t'(TON_FULL_CYC) : cnt_t'(SAMPLE_PERIOD_CYC);
      end
      // a host low that overlaps our own pulse must outlast the pulse as well
      hib_target = own_reg ? cnt_t'(MOT_PULSE_CYC + HIB_LOW_CYC) : cnt_t'(HIB_LOW_CYC);
      case (state_reg)
         ST_SETTLE: begin
            if (tmr_reg == cnt_t'(SETTLE_CYC - 1)) begin
               boot_cfg_next = boot_pin_s;
               bootp_next = boot_pin_s ? cnt_t'(BOOT_HI_CYC) : cnt_t'(C_BOOT_LO);
               tmr_next = '0;
               state_next = boot_pin_s ? ST_WINDOW : ST_STANDBY;
            end
         end
         ST_STANDBY: begin
            tmr_next = '0;
            first_next = 1'b1;
            if (hibernate_req_i) begin
               state_next = ST_HIB;
            end else if (active_req_i) begin
               state_next = ST_ACTIVE;
            end
         end
         ST_ACTIVE: begin
            if (!active_req_i) begin
               state_next = ST_STANDBY;
            end else if (tmr_reg >= sample_target - cnt_t'(1)) begin
               sample_ready_pulse_next = cnt_t'(C_SAMPLE_READY_PULSE);
               tmr_next = '0;
               first_next = 1'b0;
            end
         end
         ST_WINDOW: begin
            // the window opens only once the line is seen high
            if (tmr_reg == '0 && !line_f) begin
               tmr_next = '0;
            end
            if (line_f && !line_q_reg && low_reg != '0) begin
               for (int i = 0; i < 3; i++) begin
                  if (low_reg >= cnt_t'(THR_MIN_CYC[i]) && low_reg <= cnt_t'(THR_MAX_CYC[i])) begin
                     thr_next = 2'(i + 1);
                  end
               end
            end
            if (tmr_reg == cnt_t'(WIN_CYC - 1)) begin
               state_next = ST_MOTION;
               tmr_next = '0;
            end
         end
         ST_MOTION: begin
            if (motion_event_i && mpulse_reg == '0 && line_f) begin
               mpulse_next = cnt_t'(MOT_PULSE_CYC);
               own_next = 1'b1;
            end else if (line_f && mpulse_reg == '0) begin
               own_next = 1'b0;
            end
            if (low_reg >= hib_target) begin
               state_next = ST_HIB;
               mpulse_next = '0;
               own_next = 1'b0;
            end
         end
         ST_HIB: begin
            // on the line strap the entry low is finished first and the next falling edge wakes us; on the pin strap a low wake_n does
            if (boot_cfg_reg ? (line_q_reg && !line_f) : !wake_f) begin
               state_next = boot_cfg_reg ? ST_MOTION : ST_STANDBY;
            end
         end
         default: begin
            state_next = ST_SETTLE;
         end
      endcase
   end

   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         state_reg <= ST_SETTLE;
         tmr_reg <= '0;
         bootp_reg <= '0;
         sample_ready_pulse_reg <= '0;
         mpulse_reg <= '0;
         low_reg <= '0;
         own_reg <= 1'b0;
         line_q_reg <= 1'b1;
         first_reg <= 1'b1;
         boot_cfg_reg <= 1'b0;
         thr_reg <= THR_RESET;
         temp_reg <= '0;
         port_en_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         tmr_reg <= tmr_next;
         bootp_reg <= bootp_next;
         sample_ready_pulse_reg <= sample_ready_pulse_next;
         mpulse_reg <= mpulse_next;
         low_reg <= low_next;
         own_reg <= own_next;
         line_q_reg <= line_q_next;
         first_reg <= first_next;
         boot_cfg_reg <= boot_cfg_next;
         thr_reg <= thr_next;
         temp_reg <= temp_next;
         port_en_reg <= port_en_next;
      end
   end

   assign link.motion_line_dev_out = 1'b0;
   assign link.motion_line_dev_oe = (mpulse_reg != '0);
   assign link.boot_done = (bootp_reg != '0);
   assign link.sample_ready_pulse = (sample_ready_pulse_reg != '0);
   assign temp_code_o = temp_reg;
   assign threshold_o = thr_reg;
   assign hibernating_o = (state_reg == ST_HIB);
   assign motion_mode_o = (state_reg == ST_MOTION);
   assign i2c_port_en_o = port_en_reg;
endmodule
`default_nettype wire

// ==== hw/motion_link_host.sv ====
/*
 Host end: drives the straps, sends threshold, hibernate and wake pulses, reports sensor events.
 Assumes the device end is joined through motion_link_if; pins from it arrive asynchronously.
*/
`default_nettype none
module motion_link_host
   import motion_link_pkg::*;
#(
   parameter int WIN_CYC = C_WIN_MIN,
   parameter int HIB_CYC = C_HIB_NOM,
   parameter int LINE_WAKE_CYC = C_HOST_WAKE,
   parameter int THR_NOM_CYC [3] = C_THR_NOM
) (
   input wire logic clk_sys_i,
   input wire logic rst_i,
   motion_link_if.host link,
   input wire logic boot_config_i,
   input wire logic port_select_i,
   input wire logic thr_req_i,
   input wire logic [1:0] thr_sel_i,
   input wire logic hib_req_i,
   input wire logic wake_req_i,
   output logic ready_o,
   output logic window_o,
   output logic boot_seen_o,
   output logic motion_seen_o,
   output logic sample_seen_o
);
   typedef enum logic {H_IDLE, H_DRIVE} host_state_e;

   logic [2:0] s1_reg;
   logic [2:0] s2_reg;
   logic [2:0] q_reg;

   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         s1_reg <= 3'h1;
         s2_reg <= 3'h1;
         q_reg <= 3'h1;
      end else begin
         s1_reg <= {link.sample_ready_pulse, link.boot_done, link.motion_line};
         s2_reg <= s1_reg;
         q_reg <= s2_reg;
      end
   end

   host_state_e state_reg, state_next;
   cnt_t cnt_reg, cnt_next;
   cnt_t win_reg, win_next;
   logic drv_line_reg, drv_line_next;
   logic wake_n_reg, wake_n_next;
   logic boot_cfg_reg, boot_cfg_next;
   logic port_sel_reg, port_sel_next;
   logic boot_ev_reg, boot_ev_next;
   logic mot_ev_reg, mot_ev_next;
   logic smp_ev_reg, smp_ev_next;
   cnt_t thr_width;

   always_comb begin
      state_next = state_reg;
      cnt_next = (cnt_reg != '0) ? cnt_reg - cnt_t'(1) : cnt_reg;
      win_next = (win_reg != '0) ? win_reg - cnt_t'(1) : win_reg;
      drv_line_next = drv_line_reg;
      wake_n_next = wake_n_reg;
      boot_cfg_next = boot_config_i;
      port_sel_next = port_select_i;
      boot_ev_next = s2_reg[1] && !q_reg[1];
      smp_ev_next = s2_reg[2] && !q_reg[2];
      // a low we are not driving, outside the window, is the sensor's motion pulse
      mot_ev_next = !s2_reg[0] && q_reg[0] && !drv_line_reg && win_reg == '0;
      thr_width = (thr_sel_i == 2'h0) ? '0 : cnt_t'(THR_NOM_CYC[thr_sel_i - 2'h1]);
      if (boot_ev_next && boot_cfg_reg) begin
         win_next = cnt_t'(WIN_CYC);
      end
      case (state_reg)
         H_IDLE: begin
            if (thr_req_i && thr_sel_i != 2'h0 && win_reg > thr_width) begin
               cnt_next = thr_width;
               drv_line_next = 1'b1;
               state_next = H_DRIVE;
            end else if (hib_req_i && win_reg == '0) begin
               cnt_next = cnt_t'(HIB_CYC);
               drv_line_next = 1'b1;
               state_next = H_DRIVE;
            end else if (wake_req_i) begin
               if (boot_cfg_reg) begin
                  cnt_next = cnt_t'(LINE_WAKE_CYC);
                  drv_line_next = 1'b1;
               end else begin
                  cnt_next = cnt_t'(C_WAKE_N);
                  wake_n_next = 1'b0;
               end
               state_next = H_DRIVE;
            end
         end
         H_DRIVE: begin
            if (cnt_reg == cnt_t'(1)) begin
               drv_line_next = 1'b0;
               wake_n_next = 1'b1;
               state_next = H_IDLE;
            end
         end
         default: begin
            state_next = H_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         state_reg <= H_IDLE;
         cnt_reg <= '0;
         win_reg <= '0;
         drv_line_reg <= 1'b0;
         wake_n_reg <= 1'b1;
         boot_cfg_reg <= 1'b0;
         port_sel_reg <= 1'b0;
         boot_ev_reg <= 1'b0;
         mot_ev_reg <= 1'b0;
         smp_ev_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
         win_reg <= win_next;
         drv_line_reg <= drv_line_next;
         wake_n_reg <= wake_n_next;
         boot_cfg_reg <= boot_cfg_next;
         port_sel_reg <= port_sel_next;
         boot_ev_reg <= boot_ev_next;
         mot_ev_reg <= mot_ev_next;
         smp_ev_reg <= smp_ev_next;
      end
   end

   assign link.boot_config_pin = boot_cfg_reg;
   assign link.host_port_select = port_sel_reg;
   assign link.wake_n = wake_n_reg;
   assign link.motion_line_host_out = 1'b0;
   assign link.motion_line_host_oe = drv_line_reg;
   assign ready_o = (state_reg == H_IDLE);
   assign window_o = (win_reg != '0);
   assign boot_seen_o = boot_ev_reg;
   assign motion_seen_o = mot_ev_reg;
   assign sample_seen_o = smp_ev_reg;
endmodule
`default_nettype wire

// ==== bench/motion_link_asserts.sv ====
/*
 Concurrent checks on the pins between the sensor end and the host end.
 Assumes one clock domain and the shortened counts handed down by the bench.
*/
`default_nettype none
module motion_link_asserts
   import motion_link_pkg::*;
#(
   parameter int BOOT_HI_CYC = C_BOOT_HI,
   parameter int MOT_PULSE_CYC = C_MOT_NOM,
   parameter int SAMPLE_PERIOD_CYC = 5000
) (
   input wire logic clk_sys_i,
   input wire logic rst_i,
   input wire logic boot_config_pin,
   input wire logic boot_done,
   input wire logic sample_ready_pulse,
   input wire logic motion_line_dev_oe,
   input wire logic motion_line_host_oe
);
   cnt_t bd_cnt_reg, sr_cnt_reg, sr_gap_reg, mo_cnt_reg;
   logic bd_done_reg;

   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (rst_i);

   // gap starts saturated so the first pulse after reset is not taken for a period
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         bd_cnt_reg <= '0;
         sr_cnt_reg <= '0;
         mo_cnt_reg <= '0;
         sr_gap_reg <= '1;
         bd_done_reg <= 1'b0;
      end else begin
         bd_cnt_reg <= boot_done ? bd_cnt_reg + cnt_t'(1) : '0;
         sr_cnt_reg <= sample_ready_pulse ? sr_cnt_reg + cnt_t'(1) : '0;
         mo_cnt_reg <= motion_line_dev_oe ? mo_cnt_reg + cnt_t'(1) : '0;
         sr_gap_reg <= (sample_ready_pulse && sr_cnt_reg == '0) ? cnt_t'(1) :
                       (&sr_gap_reg ? sr_gap_reg : sr_gap_reg + cnt_t'(1));
         bd_done_reg <= bd_done_reg || (!boot_done && bd_cnt_reg != '0);
      end
   end

   a_boot_width: assert property (
      $fell(boot_done) |-> bd_cnt_reg == cnt_t'(boot_config_pin ? BOOT_HI_CYC : C_BOOT_LO))
      else $error("boot pulse width wrong");
   // bound suits the shortened settle count only
   a_boot_prompt: assert property (
      $fell(rst_i) |-> ##[0:1000] boot_done)
      else $error("boot pulse late after reset");
   a_boot_once: assert property (
      $rose(boot_done) |-> !bd_done_reg)
      else $error("second boot pulse without reset");
   a_ready_width: assert property (
      $fell(sample_ready_pulse) |-> sr_cnt_reg == cnt_t'(C_SAMPLE_READY_PULSE))
      else $error("sample ready width wrong");
   a_ready_strap: assert property (
      sample_ready_pulse |-> !boot_config_pin)
      else $error("sample ready with boot pin high");
   a_ready_period: assert property (
      $rose(sample_ready_pulse) && sr_gap_reg < cnt_t'(SAMPLE_PERIOD_CYC * 3 / 2) |->
      sr_gap_reg >= cnt_t'(SAMPLE_PERIOD_CYC * 9 / 10) && sr_gap_reg <= cnt_t'(SAMPLE_PERIOD_CYC * 11 / 10))
      else $error("sample period out of tolerance");
   a_motion_width: assert property (
      $fell(motion_line_dev_oe) && !motion_line_host_oe |-> mo_cnt_reg == cnt_t'(MOT_PULSE_CYC))
      else $error("motion pulse width wrong");
   a_motion_strap: assert property (
      motion_line_dev_oe |-> boot_config_pin)
      else $error("motion pulse with boot pin low");
   a_motion_hold: assert property (
      $rose(motion_line_dev_oe) |-> motion_line_dev_oe [*8])
      else $error("motion pulse dropped early");
endmodule
`default_nettype wire

// ==== bench/motion_pin_boot_signalling_test.sv ====
/*
 Bench for the motion line link: both ends joined through the pin bundle, user sides driven here.
 Assumes the shortened counts below; the line and wake filters keep their full length.
*/
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin errors++; $display("[ERR] %s exp %0d got %0d", nm, e, g); end end
module motion_pin_boot_signalling_test
   import motion_link_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int MOT = 3000;
   localparam int BOOT_HI = 200;
   localparam int PER = 5000;
   localparam int TON = 100;
   localparam int TON_DEC = int'($floor(0.9984 * 3.0 * 125.0e6 / (25000.0 * 4.0)));
   logic clk_sys_i = 1'b0, rst_i = 1'b1;
   logic motion_event = 1'b0, active_req = 1'b0, hib_dev = 1'b0, reduced_pow = 1'b0;
   logic boot_cfg = 1'b0, port_sel = 1'b0, thr_req = 1'b0, hib_req = 1'b0, wake_req = 1'b0;
   logic signed [7:0] temp_c = 8'sh00, temp_code, exp_t;
   logic [1:0] threshold, thr_prev, exp_thr, thr_sel = 2'h0;
   logic hibernating, motion_mode, i2c_en, ready, window, boot_seen, motion_seen, sample_seen;
   int errors, n_checks, cycles, w_bd, w_sr, w_mo;
   int q_w[$];
   logic [1:0] q_t[$];
   motion_link_if lk();
   motion_link_device #(.SAMPLE_RATE_HZ(25000), .DECIMATION(4), .SETTLE_CYC(20), .BOOT_HI_CYC(BOOT_HI),
      .WIN_CYC(22000), .MOT_PULSE_CYC(MOT), .HIB_LOW_CYC(2000), .TON_BASE_CYC(TON), .SAMPLE_PERIOD_CYC(PER),
      .THR_MIN_CYC('{1500, 3000, 6000}), .THR_MAX_CYC('{2000, 4000, 8000})) motion_link_device_inst (
      .clk_sys_i(clk_sys_i), .rst_i(rst_i), .link(lk.dev), .motion_event_i(motion_event),
      .active_req_i(active_req), .hibernate_req_i(hib_dev), .reduced_power_operation_i(reduced_pow),
      .temp_celsius_i(temp_c), .temp_code_o(temp_code), .threshold_o(threshold), .hibernating_o(hibernating),
      .motion_mode_o(motion_mode), .i2c_port_en_o(i2c_en));
   motion_link_host #(.WIN_CYC(18000), .HIB_CYC(2500), .LINE_WAKE_CYC(1400),
      .THR_NOM_CYC('{1750, 3500, 7000})) motion_link_host_inst (
      .clk_sys_i(clk_sys_i), .rst_i(rst_i), .link(lk.host), .boot_config_i(boot_cfg), .port_select_i(port_sel),
      .thr_req_i(thr_req), .thr_sel_i(thr_sel), .hib_req_i(hib_req), .wake_req_i(wake_req), .ready_o(ready),
      .window_o(window), .boot_seen_o(boot_seen), .motion_seen_o(motion_seen), .sample_seen_o(sample_seen));
   motion_link_asserts #(.BOOT_HI_CYC(BOOT_HI), .MOT_PULSE_CYC(MOT), .SAMPLE_PERIOD_CYC(PER))
      motion_link_asserts_inst (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .boot_config_pin(lk.boot_config_pin),
      .boot_done(lk.boot_done), .sample_ready_pulse(lk.sample_ready_pulse),
      .motion_line_dev_oe(lk.motion_line_dev_oe), .motion_line_host_oe(lk.motion_line_host_oe));

   always #4 clk_sys_i = ~clk_sys_i;

   task automatic cyc(input int n);
      repeat (n) @(negedge clk_sys_i);
   endtask
   task automatic pulse(ref logic s);
      s = 1'b1;
      cyc(1);
      s = 1'b0;
   endtask
   task automatic wait_val(ref logic s, input logic v, input int lim);
      for (int i = 0; i < lim && s !== v; i++) cyc(1);
   endtask
   task automatic note(input string nm, ref int got);
      int e;
      e = (q_w.size() > 0) ? q_w.pop_front() : -1;
      `CHK(nm, e, got)
      got = 0;
   endtask
   task automatic test_done();
      `CHK("pending notes", 0, q_w.size() + q_t.size())
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task automatic reset_to(input logic strap, input logic psel);
      rst_i = 1'b1;
      boot_cfg = strap;
      port_sel = psel;
      cyc(12);
      rst_i = 1'b0;
   endtask
   // the period is counted rise to rise, so the count runs on across the high phase
   task automatic sample_run(input logic rp, input int ton, input int n);
      int c = 0;
      reduced_pow = rp;
      repeat (n) q_w.push_back(4000);
      active_req = 1'b1;
      for (int k = 0; k < n; k++) begin
         for (; c < 20000 && lk.sample_ready_pulse !== 1'b1; c++) cyc(1);
         if (k == 0) `CHK("first sample", 1'b1, c >= ton && c <= ton + 8)
         else `CHK("sample period", 1'b1, c >= PER * 9 / 10 && c <= PER * 11 / 10)
         cyc(3);
         `CHK("sample seen", 1'b1, sample_seen)
         c = 3;
         for (; c < 20000 && lk.sample_ready_pulse === 1'b1; c++) cyc(1);
      end
      active_req = 1'b0;
   endtask
   task automatic send_thr(input logic [1:0] s, input logic ok);
      wait_val(ready, 1'b1, 20000);
      thr_sel = s;
      pulse(thr_req);
      `CHK("host threshold pulse", {ok, !ok}, {lk.motion_line_host_oe, ready})
      if (ok) q_t.push_back(s);
      wait_val(ready, 1'b1, 20000);
      cyc(1400);
   endtask

   always @(posedge clk_sys_i) begin
      if (lk.boot_done === 1'b1) w_bd++;
      else if (w_bd > 0) note("boot width", w_bd);
      if (lk.sample_ready_pulse === 1'b1) w_sr++;
      else if (w_sr > 0) note("sample ready width", w_sr);
      if (lk.motion_line_dev_oe === 1'b1) w_mo++;
      else if (w_mo > 0) note("motion width", w_mo);
      if (rst_i === 1'b0 && threshold !== thr_prev) begin
         exp_thr = (q_t.size() > 0) ? q_t.pop_front() : 2'bxx;
         `CHK("threshold", exp_thr, threshold)
      end
      thr_prev = threshold;
   end

   always @(posedge clk_sys_i) begin
      cycles++;
      if (cycles == 100000) begin
         errors++;
         $display("[ERR] run length exp below 100000 got %0d", cycles);
         test_done();
      end
   end

   initial begin
      void'($urandom(39));
      q_w.push_back(8000);
      reset_to(1'b0, 1'b0);
      wait_val(boot_seen, 1'b1, 200);
      `CHK("boot seen", 1'b1, boot_seen)
      `CHK("port enable", 1'b1, i2c_en)
      wait_val(lk.boot_done, 1'b0, 9000);
      for (int k = 0; k < 6; k++) begin
         temp_c = 8'($urandom);
         motion_event = 1'($urandom);
         {thr_req, thr_sel} = 3'($urandom);
         exp_t = temp_c - 8'sd25;
         cyc(2);
         `CHK("temp code", exp_t, temp_code)
         `CHK("line idle", 2'h3, {lk.motion_line, ready})
      end
      {motion_event, thr_req} = 2'h0;
      sample_run(1'b1, TON, 3);
      cyc(8000);
      sample_run(1'b0, TON + TON_DEC, 2);
      cyc(8000);
      hib_dev = 1'b1;
      wait_val(hibernating, 1'b1, 50);
      hib_dev = 1'b0;
      `CHK("standby hibernate", 1'b1, hibernating)
      pulse(wake_req);
      wait_val(hibernating, 1'b0, 400);
      `CHK("pin wake", 1'b0, hibernating)
      q_w.push_back(BOOT_HI);
      reset_to(1'b1, 1'b1);
      wait_val(boot_seen, 1'b1, 200);
      `CHK("boot seen", 1'b1, boot_seen)
      `CHK("port enable", 1'b0, i2c_en)
      for (int s = 0; s < 4; s++) send_thr(2'(s), s != 0);
      pulse(wake_req); // a low that matches no threshold width
      wait_val(ready, 1'b1, 20000);
      cyc(1400);
      `CHK("threshold kept", 2'h3, threshold)
      wait_val(motion_mode, 1'b1, 12000);
      `CHK("motion mode", 1'b1, motion_mode)
      `CHK("window closed", 1'b0, window)
      send_thr(2'h2, 1'b0);
      q_w.push_back(MOT);
      pulse(motion_event);
      wait_val(motion_seen, 1'b1, 2000);
      `CHK("motion seen", 1'b1, motion_seen)
      cyc(MOT + 1400);
      pulse(hib_req);
      wait_val(hibernating, 1'b1, 5000);
      `CHK("line hibernate", 1'b1, hibernating)
      cyc(2000);
      pulse(wake_req);
      wait_val(motion_mode, 1'b1, 5000);
      `CHK("line wake", 1'b1, motion_mode)
      cyc(20);
      test_done();
   end
endmodule
`default_nettype wire
